// *** verilog/temp_mon_pkg.sv ***
// constants shared by the two-channel temperature monitor core
// assumes one 200 MHz clock and a synchronous active-high reset
// Behaviour
// - converter runs continuously, each conversion started without external trigger
// - channel selection alternates between on-chip and remote sensor
// - each result goes into its channel's value register, 8-bit twos complement
// - each value compared with its channel's high and low limit
// - out-of-limit comparison sets status flag; any set flag pulls alert low while the alert mask is clear
// - all registers readable by host; limits and control writable
// - control selects normal or standby, alert mask, and conversion rate
// - value registers hold minus 128 after reset until a measurement lands
// - powering up converting measures both channels before the first comparison
// - powering up in standby compares reset values, tripping both low flags
// - each reported result is the average of 16 raw measurement cycles
// - excitation switches between base current and multiple during each measurement
// - status read clears flags except those whose condition still holds
package temp_mon_pkg;
  localparam int          TEMP_W          = 8;
  localparam int          AVG_SAMPLES     = 16;
  localparam int          AVG_SHIFT       = 4;
  localparam int          SUM_W           = TEMP_W + AVG_SHIFT;
  localparam logic [7:0]  VALUE_RST       = 8'h80;
  localparam int          RATE_W          = 3;
  localparam logic [2:0]  RATE_RST        = 3'h2;
  localparam int          BOOT_SETTLE     = 3;
  // status bit positions
  localparam int          ST_BUSY         = 7;
  localparam int          ST_LHIGH        = 6;
  localparam int          ST_LOCAL_LOW_TRIP_FLAG         = 5;
  localparam int          ST_RHIGH        = 4;
  localparam int          ST_REMOTE_LOW_TRIP_FLAG         = 3;
  localparam int          ST_OPEN         = 2;
  // base conversion period in ms, halved per rate step
  localparam int          CONV_BASE_MS    = 16000;
  localparam longint      CLK_HZ          = 200_000_000;
  localparam longint      CONV_BASE_CYC   = (CLK_HZ * CONV_BASE_MS) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXLO  = 2'b01,
    ST_EXHI  = 2'b11,
    ST_STORE = 2'b10
  } conv_state_t;
endpackage : temp_mon_pkg

// *** verilog/conv_rate_tick.sv ***
// conversion rate divider: one-cycle tick per conversion period
// assumes rate code from host logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module conv_rate_tick #(
  parameter longint BASE_CYCLES = temp_mon_pkg::CONV_BASE_CYC
) (
  input  wire logic                           sys_clk_in,
  input  wire logic                           rst_in,
  input  wire logic                           run_in,
  input  wire logic [temp_mon_pkg::RATE_W-1:0] rate_in,
  output logic                                tick_out
);
  import temp_mon_pkg::*;

  logic [39:0] cnt_ff;
  logic [39:0] period;

  // faster rates shorten the period; a rate change takes effect at the next wrap
  assign period = 40'(BASE_CYCLES >> rate_in);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !run_in) begin
      cnt_ff   <= 40'h00_0000_0000;
      tick_out <= 1'b0;
    end else if (cnt_ff == 40'h00_0000_0000) begin
      cnt_ff   <= (period > 40'h00_0000_0001) ? period - 40'h00_0000_0001 : 40'h00_0000_0000;
      tick_out <= 1'b1;
    end else begin
      cnt_ff   <= cnt_ff - 40'h00_0000_0001;
      tick_out <= 1'b0;
    end
  end
endmodule : conv_rate_tick
`default_nettype wire

// *** verilog/sample_averager.sv ***
// accumulates raw twos complement samples and yields their mean
// assumes clear and add come from the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module sample_averager (
  input  wire logic                              sys_clk_in,
  input  wire logic                              rst_in,
  input  wire logic                              clear_in,
  input  wire logic                              add_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]   sample_in,
  output logic      [temp_mon_pkg::TEMP_W-1:0]   mean_out
);
  import temp_mon_pkg::*;

  logic signed [SUM_W-1:0] sum_ff;
  logic signed [SUM_W-1:0] nxt_sum;

  // sign extend so negative codes average correctly
  assign nxt_sum = sum_ff + SUM_W'($signed(sample_in));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in || clear_in) begin
      sum_ff <= '0;
    end else if (add_in) begin
      sum_ff <= nxt_sum;
    end
  end

  // truncating divide by 16; floor toward minus infinity
  assign mean_out = sum_ff[SUM_W-1:AVG_SHIFT];
endmodule : sample_averager
`default_nettype wire

// *** verilog/temp_monitor_core.sv ***
// conversion sequencer, value and status registers, limit compare and alert
// assumes an analog front end handshaking on adc_start_out/adc_done_in on this clock,
// and host-side register logic presenting limits and control as plain levels
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_core #(
  parameter longint CONV_BASE_CYCLES = temp_mon_pkg::CONV_BASE_CYC
) (
  input  wire logic                                sys_clk_in,
  input  wire logic                                rst_in,
  input  wire logic                                standby_select_n_in,
  input  wire logic                                sensor_open_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]     local_high_limit_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]     local_low_limit_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]     remote_high_limit_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]     remote_low_limit_in,
  input  wire logic                                sw_standby_in,
  input  wire logic                                alert_mask_in,
  input  wire logic [temp_mon_pkg::RATE_W-1:0]     conv_rate_in,
  input  wire logic                                status_read_in,
  input  wire logic                                adc_done_in,
  input  wire logic [temp_mon_pkg::TEMP_W-1:0]     adc_data_in,
  output logic                                     adc_start_out,
  output logic                                     excite_high_out,
  output logic                                     channel_remote_out,
  output logic      [temp_mon_pkg::TEMP_W-1:0]     local_value_out,
  output logic      [temp_mon_pkg::TEMP_W-1:0]     remote_value_out,
  output logic      [7:0]                          status_out,
  output logic                                     alert_n_out
);
  import temp_mon_pkg::*;

  // signed compare helpers used for both the update compare and the live one
  function automatic logic above(input logic [7:0] v, input logic [7:0] lim);
    above = $signed(v) > $signed(lim);
  endfunction : above

  function automatic logic below(input logic [7:0] v, input logic [7:0] lim);
    below = $signed(v) < $signed(lim);
  endfunction : below

  // true while a front end phase is outstanding
  function automatic logic in_phase(input conv_state_t s);
    in_phase = (s == ST_EXLO) || (s == ST_EXHI);
  endfunction : in_phase

  // pin synchronisers
  logic        standby_select_n_meta_ff;
  logic        standby_select_n_sync_ff;
  logic        open_meta_ff;
  logic        open_sync_ff;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      standby_select_n_meta_ff <= 1'b1;
      standby_select_n_sync_ff <= 1'b1;
      open_meta_ff <= 1'b0;
      open_sync_ff <= 1'b0;
    end else begin
      standby_select_n_meta_ff <= standby_select_n_in;
      standby_select_n_sync_ff <= standby_select_n_meta_ff;
      open_meta_ff <= sensor_open_in;
      open_sync_ff <= open_meta_ff;
    end
  end

  // power-up decision waits for the synchroniser to carry the real pin level
  logic [1:0]  boot_cnt_ff;
  logic        boot_done_ff;
  logic        boot_cmp;
  logic        running;

  assign running  = boot_done_ff && standby_select_n_sync_ff && !sw_standby_in;
  assign boot_cmp = !boot_done_ff && (boot_cnt_ff == 2'(BOOT_SETTLE - 1));

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      boot_cnt_ff  <= 2'h0;
      boot_done_ff <= 1'b0;
    end else if (boot_cmp) begin
      boot_done_ff <= 1'b1;
    end else if (!boot_done_ff) begin
      boot_cnt_ff  <= boot_cnt_ff + 2'h1;
    end
  end

  // standby at power-up: no conversion, compare reset values at once
  logic        standby_boot_cmp;
  assign standby_boot_cmp = boot_cmp && (!standby_select_n_sync_ff || sw_standby_in);

  // conversion pacing
  logic        conv_tick;
  logic        conv_pending_ff;

  conv_rate_tick #(
    .BASE_CYCLES (CONV_BASE_CYCLES)
  ) u_rate (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .run_in      (running),
    .rate_in     (conv_rate_in),
    .tick_out    (conv_tick)
  );

  // conversion sequencer
  conv_state_t state_ff;
  logic [3:0]  raw_cnt_ff;
  logic        chan_ff;
  logic        avg_clear;
  logic        avg_add;
  logic [7:0]  avg_mean;
  logic        conv_start;
  logic        conv_end;
  logic        last_high;
  logic        local_store;

  assign conv_start = (state_ff == ST_IDLE) && conv_pending_ff && running;
  assign avg_add    = (state_ff == ST_EXHI) && adc_done_in;
  assign avg_clear  = conv_start || (state_ff == ST_STORE);
  assign conv_end   = (state_ff == ST_STORE) && chan_ff;
  // last high phase of a channel issues no start; the local store state does
  assign last_high   = (state_ff == ST_EXHI) && (raw_cnt_ff == 4'(AVG_SAMPLES - 1));
  assign local_store = (state_ff == ST_STORE) && !chan_ff;

  // a tick seen while busy is held so no period is dropped
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      conv_pending_ff <= 1'b0;
    end else if (conv_tick) begin
      conv_pending_ff <= 1'b1;
    end else if (conv_start) begin
      conv_pending_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_ff   <= ST_IDLE;
      raw_cnt_ff <= 4'h0;
      chan_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (conv_start) begin
            state_ff   <= ST_EXLO;
            raw_cnt_ff <= 4'h0;
            chan_ff    <= 1'b0;
          end
        end
        ST_EXLO: begin
          if (adc_done_in) begin
            state_ff <= ST_EXHI;
          end
        end
        ST_EXHI: begin
          if (adc_done_in) begin
            raw_cnt_ff <= raw_cnt_ff + 4'h1;
            state_ff   <= (raw_cnt_ff == 4'(AVG_SAMPLES - 1)) ? ST_STORE : ST_EXLO;
          end
        end
        ST_STORE: begin
          raw_cnt_ff <= 4'h0;
          if (chan_ff) begin
            state_ff <= ST_IDLE;
          end else begin
            chan_ff  <= 1'b1;
            state_ff <= ST_EXLO;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  sample_averager u_avg (
    .sys_clk_in  (sys_clk_in),
    .rst_in      (rst_in),
    .clear_in    (avg_clear),
    .add_in      (avg_add),
    .sample_in   (adc_data_in),
    .mean_out    (avg_mean)
  );

  // front end drive: one start pulse per excitation phase
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      adc_start_out      <= 1'b0;
      excite_high_out    <= 1'b0;
      channel_remote_out <= 1'b0;
    end else begin
      adc_start_out      <= conv_start ||
                            (in_phase(state_ff) && adc_done_in && !last_high) ||
                            local_store;
      excite_high_out    <= (state_ff == ST_EXLO) && adc_done_in ||
                            (state_ff == ST_EXHI) && !adc_done_in;
      channel_remote_out <= (state_ff == ST_STORE) ? 1'b1 :
                            (conv_start ? 1'b0 : chan_ff);
    end
  end

  // value registers
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      local_value_out  <= VALUE_RST;
      remote_value_out <= VALUE_RST;
    end else if (state_ff == ST_STORE) begin
      if (chan_ff) begin
        remote_value_out <= avg_mean;
      end else begin
        local_value_out  <= avg_mean;
      end
    end
  end

  // a channel is compared whenever its value register is rewritten, but the
  // first conversion after a converting power-up waits for both values
  logic        seeded_ff;
  logic        cmp_local_ff;
  logic        cmp_remote_ff;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      seeded_ff <= 1'b0;
    end else if (conv_end || standby_boot_cmp) begin
      seeded_ff <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cmp_local_ff  <= 1'b0;
      cmp_remote_ff <= 1'b0;
    end else begin
      cmp_local_ff  <= (local_store && seeded_ff) || (conv_end && !seeded_ff) ||
                       standby_boot_cmp;
      cmp_remote_ff <= conv_end || standby_boot_cmp;
    end
  end

  logic [3:0]  live_trip;
  assign live_trip = {above(local_value_out, local_high_limit_in),
                      below(local_value_out, local_low_limit_in),
                      above(remote_value_out, remote_high_limit_in),
                      below(remote_value_out, remote_low_limit_in)};

  // flags: sets win over the read clear; a live condition keeps its flag
  logic [3:0]  trip_ff;
  logic        open_flag_ff;
  logic [3:0]  trip_set;

  // each half of the flag word is set only by its own channel's compare
  assign trip_set = {cmp_local_ff ? live_trip[3:2] : 2'h0,
                     cmp_remote_ff ? live_trip[1:0] : 2'h0};

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      trip_ff <= 4'h0;
    end else if (status_read_in) begin
      trip_ff <= (trip_ff & live_trip) | trip_set;
    end else begin
      trip_ff <= trip_ff | trip_set;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      open_flag_ff <= 1'b0;
    end else if (status_read_in) begin
      open_flag_ff <= open_sync_ff;
    end else begin
      open_flag_ff <= open_flag_ff | open_sync_ff;
    end
  end

  logic        busy;
  assign busy = (state_ff != ST_IDLE);

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      status_out <= 8'h00;
    end else begin
      status_out           <= 8'h00;
      status_out[ST_BUSY]  <= busy;
      status_out[ST_LHIGH] <= trip_ff[3];
      status_out[ST_LOCAL_LOW_TRIP_FLAG]  <= trip_ff[2];
      status_out[ST_RHIGH] <= trip_ff[1];
      status_out[ST_REMOTE_LOW_TRIP_FLAG]  <= trip_ff[0];
      status_out[ST_OPEN]  <= open_flag_ff;
    end
  end

  // mask hides both pending and later alerts
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      alert_n_out <= 1'b1;
    end else begin
      alert_n_out <= !((|trip_ff || open_flag_ff) && !alert_mask_in);
    end
  end
endmodule : temp_monitor_core
`default_nettype wire

// *** tb/temp_monitor_core_assertions.sv ***
// port-level checker for the temperature monitor core
// assumes a bind onto temp_monitor_core and flags on status bits 6..2
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_core_assertions #(
  parameter longint CONV_BASE_CYCLES = 600
) (
  input wire logic                            sys_clk_in,
  input wire logic                            rst_in,
  input wire logic                            standby_select_n_in,
  input wire logic                            sw_standby_in,
  input wire logic                            alert_mask_in,
  input wire logic                            status_read_in,
  input wire logic                            adc_done_in,
  input wire logic                            adc_start_out,
  input wire logic                            excite_high_out,
  input wire logic                            channel_remote_out,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] local_value_out,
  input wire logic [temp_mon_pkg::TEMP_W-1:0] remote_value_out,
  input wire logic [7:0]                      status_out,
  input wire logic                            alert_n_out
);
  import temp_mon_pkg::*;
  longint idle_ff;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // slack covers the pin synchroniser and the rate counter restart
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || status_out[ST_BUSY] || !standby_select_n_in || sw_standby_in) idle_ff <= 0;
    else idle_ff <= idle_ff + 1;
  end
  property p_free_run; idle_ff <= CONV_BASE_CYCLES + 8; endproperty
  a_free_run: assert property (p_free_run) else $error("converter stalled");
  property p_start_pulse; adc_start_out |=> !adc_start_out; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_excite; adc_done_in && status_out[ST_BUSY] |=> $changed(excite_high_out); endproperty
  a_excite: assert property (p_excite) else $error("excitation did not switch");
  property p_local_ch; $changed(local_value_out) |-> !$past(channel_remote_out); endproperty
  a_local_ch: assert property (p_local_ch) else $error("local value from remote");
  property p_remote_ch; $changed(remote_value_out) |-> $past(channel_remote_out); endproperty
  a_remote_ch: assert property (p_remote_ch) else $error("remote value from local");
  property p_alert_on;
    status_out[6:2] != 5'h00 && !$past(alert_mask_in) |-> !alert_n_out;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert missing");
  property p_alert_off; status_out[6:2] == 5'h00 |-> alert_n_out; endproperty
  a_alert_off: assert property (p_alert_off) else $error("alert without flag");
  property p_mask; alert_mask_in ##1 alert_mask_in |-> alert_n_out; endproperty
  a_mask: assert property (p_mask) else $error("masked alert shown");
  property p_clear; ($past(status_out[6:3]) & ~status_out[6:3]) != 4'h0 |-> $past(status_read_in, 2);
  endproperty
  a_clear: assert property (p_clear) else $error("flag dropped unread");
endmodule : temp_monitor_core_assertions
bind temp_monitor_core temp_monitor_core_assertions #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) chk_inst (
  .sys_clk_in(sys_clk_in), .rst_in(rst_in), .standby_select_n_in(standby_select_n_in),
  .sw_standby_in(sw_standby_in), .alert_mask_in(alert_mask_in), .status_read_in(status_read_in),
  .adc_done_in(adc_done_in), .adc_start_out(adc_start_out), .excite_high_out(excite_high_out),
  .channel_remote_out(channel_remote_out), .local_value_out(local_value_out),
  .remote_value_out(remote_value_out), .status_out(status_out), .alert_n_out(alert_n_out));
`default_nettype wire

// *** tb/adc_front_model.sv ***
// behavioural analog front end answering each start with one done pulse
// assumes start is a one-cycle pulse; latency alternates prompt and slow
`timescale 1ns/1ps
`default_nettype none
module adc_front_model (
  input  wire logic       sys_clk_in,
  input  wire logic       adc_start_in,
  input  wire logic       excite_high_in,
  input  wire logic       channel_remote_in,
  input  wire logic [7:0] local_code_in,
  input  wire logic [7:0] remote_code_in,
  output logic            done_out,
  output logic [7:0]      data_out
);
  int   wait_ff = -1;
  logic slow_ff = 1'b0;
  logic flip_ff = 1'b0;
  initial done_out = 1'b0;
  initial data_out = 8'h00;
  always @(negedge sys_clk_in) begin
    done_out <= 1'b0;
    // data is only valid with done, so scramble it otherwise
    data_out <= ~data_out;
    if (adc_start_in) wait_ff <= slow_ff ? 5 : 1;
    else if (wait_ff > 0) wait_ff <= wait_ff - 1;
    else if (wait_ff == 0) begin
      done_out <= 1'b1;
      wait_ff  <= -1;
      slow_ff  <= ~slow_ff;
      // local high phases alternate code and code+1, so the mean must floor
      data_out <= channel_remote_in ? remote_code_in : local_code_in + {7'h00, flip_ff};
      if (excite_high_in) flip_ff <= ~flip_ff;
    end
  end
endmodule : adc_front_model
`default_nettype wire

// *** tb/dual_channel_temp_monitor_tb.sv ***
// self-checking bench for temp_monitor_core with a behavioural front end
// assumes a shortened conversion period; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module dual_channel_temp_monitor_tb;
  import temp_mon_pkg::*;
  localparam longint BASE = 600;
  logic       sys_clk_in, rst_in, standby_select_n_n, open_in, sw_standby_select_n, mask, rd, done;
  logic       start, excite, remote_sel, alert_n;
  logic [7:0] lhi, llo, rhi, rlo, data, lcode, rcode, lval, rval, status;
  logic [2:0] rate;
  int         err_total, checks_done, cyc_total;
  temp_monitor_core #(.CONV_BASE_CYCLES(BASE)) temp_monitor_core_inst (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .standby_select_n_in(standby_select_n_n),
    .sensor_open_in(open_in), .local_high_limit_in(lhi), .local_low_limit_in(llo),
    .remote_high_limit_in(rhi), .remote_low_limit_in(rlo), .sw_standby_in(sw_standby_select_n),
    .alert_mask_in(mask), .conv_rate_in(rate), .status_read_in(rd), .adc_done_in(done),
    .adc_data_in(data), .adc_start_out(start), .excite_high_out(excite),
    .channel_remote_out(remote_sel), .local_value_out(lval), .remote_value_out(rval),
    .status_out(status), .alert_n_out(alert_n));
  adc_front_model adc_front_model_inst (
    .sys_clk_in(sys_clk_in), .adc_start_in(start), .excite_high_in(excite),
    .channel_remote_in(remote_sel), .local_code_in(lcode), .remote_code_in(rcode),
    .done_out(done), .data_out(data));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task wrap_up;
    if (err_total == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : cyc
  task read_status;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(4);
  endtask : read_status
  task automatic wait_rval(input logic [7:0] e);
    for (int i = 0; i < 3000 && rval !== e; i++) cyc(1);
  endtask : wait_rval
  task test_standby_boot;
    cyc(12);
    check(lval, 8'h80);
    check(rval, 8'h80);
    check(status & 8'h78, 8'h28);
    check(alert_n, 1'b0);
  endtask : test_standby_boot
  task test_low_clear;
    llo = 8'h80;
    rlo = 8'h80;
    read_status();
    check(status & 8'h7c, 8'h00);
    check(alert_n, 1'b1);
  endtask : test_low_clear
  task test_convert;
    standby_select_n_n = 1'b1;
    wait_rval(8'h32);
    cyc(4);
    check(lval, 8'h19);
    check(rval, 8'h32);
    read_status();
    check(status & 8'h7c, 8'h00);
    check(alert_n, 1'b1);
  endtask : test_convert
  task test_trip;
    rhi = 8'h28;
    for (int i = 0; i < 3000 && status[ST_RHIGH] !== 1'b1; i++) cyc(1);
    cyc(2);
    check(status & 8'h7c, 8'h10);
    check(alert_n, 1'b0);
    read_status();
    check(status & 8'h7c, 8'h10);
    mask = 1'b1;
    cyc(3);
    check(alert_n, 1'b1);
    rhi  = 8'h7f;
    mask = 1'b0;
    open_in = 1'b1;
    cyc(8);
    check(status & 8'h7c, 8'h14);
    open_in = 1'b0;
    cyc(4);
    read_status();
    check(status & 8'h7c, 8'h00);
  endtask : test_trip
  task test_sw_standby;
    sw_standby_select_n = 1'b1;
    rcode   = 8'h3c;
    cyc(1500);
    check(rval, 8'h32);
    sw_standby_select_n = 1'b0;
    wait_rval(8'h3c);
    check(rval, 8'h3c);
  endtask : test_sw_standby
  task test_reboot;
    {llo, rlo} = {8'hc9, 8'hc9};
    standby_select_n_n = 1'b1;
    rst_in = 1'b1;
    cyc(5);
    rst_in = 1'b0;
    cyc(12);
    check(lval, 8'h80);
    check(rval, 8'h80);
    check(status & 8'h78, 8'h00);
    wait_rval(8'h3c);
    cyc(4);
    check(lval, 8'h19);
    check(status & 8'h7c, 8'h00);
    check(alert_n, 1'b1);
  endtask : test_reboot
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // a hang anywhere ends in the same verdict path
  always @(posedge sys_clk_in) begin
    cyc_total++;
    if (cyc_total == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    {err_total, checks_done, cyc_total} = '0;
    {rst_in, standby_select_n_n, open_in, sw_standby_select_n, mask, rd} = 6'b100000;
    {lhi, rhi, llo, rlo} = {8'h7f, 8'h7f, 8'hc9, 8'hc9};
    lcode = 8'h19;
    rcode = 8'h32;
    rate  = 3'h0;
    cyc(5);
    rst_in = 1'b0;
    test_standby_boot();
    test_low_clear();
    test_convert();
    test_trip();
    test_sw_standby();
    test_reboot();
    wrap_up();
  end
endmodule : dual_channel_temp_monitor_tb
`default_nettype wire
